// >>> inc/rosr_pkg.sv
package rosr_pkg;

  // ********************************************************************
  // Register offsets
  // ********************************************************************
  localparam logic [7:0] OFFS_PIN_OVERRIDE = 8'h08;
  localparam logic [7:0] OFFS_RESERVED_A = 8'h09;
  localparam logic [7:0] OFFS_PRESENCE_MON = 8'h0a;
  localparam logic [7:0] OFFS_RESERVED_B = 8'h0b;
  localparam logic [7:0] OFFS_RESERVED_C = 8'h0c;
  localparam logic [7:0] OFFS_LANE0_FORCE = 8'h0d;

  // ********************************************************************
  // Values after reset
  // ********************************************************************
  localparam logic [7:0] RST_PIN_OVERRIDE = 8'h00;
  localparam logic [7:0] RST_RESERVED_A = 8'h00;
  localparam logic [7:0] RST_PRESENCE_MON = 8'h00;
  localparam logic [7:0] RST_RESERVED_B = 8'h70;
  localparam logic [7:0] RST_RESERVED_C = 8'h00;
  localparam logic [7:0] RST_LANE0_FORCE = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // ********************************************************************
  // Field positions
  // ********************************************************************
  localparam int unsigned BIT_THR_BLOCK = 6;
  localparam int unsigned BIT_IDLE_REGS = 4;
  localparam int unsigned BIT_RX_BLOCK = 3;
  localparam int unsigned BIT_MODE_BLOCK = 2;
  localparam int unsigned BIT_FORCE_OFF = 2;
  localparam int unsigned BIT_FORCE_ON = 1;

  // ********************************************************************
  // Serial engine
  // ********************************************************************
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [6:0] DEFAULT_SLAVE_ADDR = 7'h18;  // Value is arbitrary

  typedef enum logic [3:0] {
    SMB_IDLE,
    SMB_ADDR,
    SMB_ADDR_ACK,
    SMB_OFFS,
    SMB_OFFS_ACK,
    SMB_WDATA,
    SMB_WDATA_ACK,
    SMB_RDATA,
    SMB_RDATA_ACK
  } rosr_smb_state_t;

endpackage

// >>> src/rosr_sync.sv
`timescale 1ns/100ps

module rosr_sync
#(
  parameter int unsigned WIDTH = 1
)
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  // ********************************************************************
  // Two-stage synchroniser
  // ********************************************************************
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      stage1 <= '0;
      sync_o <= '0;
    end
    else
    begin
      stage1 <= async_i;
      sync_o <= stage1;
    end
  end

endmodule

// >>> src/rosr_regs.sv
`timescale 1ns/100ps

module rosr_regs
#(
  parameter logic [6:0] SLAVE_ADDR = rosr_pkg::DEFAULT_SLAVE_ADDR,
  parameter int unsigned LANES = 8
)
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  input wire logic detector_threshold_pin_i,
  input wire logic threshold_reg_i,
  input wire logic [1:0] receiver_sense_i,
  input wire logic [1:0] rx_mode_reg_i,
  input wire logic mode_pin_i,
  input wire logic mode_reg_i,
  input wire logic rate_float_i,
  input wire logic [LANES-1:0] lane_signal_raw_i,
  input wire logic [LANES-1:0] lane_idle_sel_i,
  output logic detector_threshold_o,
  output logic [1:0] receiver_sense_o,
  output logic mode_sel_o,
  output logic [LANES-1:0] output_idle_o,
  output logic [LANES-1:0] lane_present_o
);

  // ********************************************************************
  // Input synchronisers
  // ********************************************************************
  localparam int unsigned SYNC_W = 7 + LANES;

  logic [SYNC_W-1:0] sync_out;
  logic scl_s;
  logic sda_s;
  logic thr_s;
  logic [1:0] rxs_s;
  logic mode_s;
  logic rate_s;
  logic [LANES-1:0] raw_s;

  rosr_sync #(.WIDTH(SYNC_W)) u_sync
  (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .async_i({lane_signal_raw_i, rate_float_i, mode_pin_i, receiver_sense_i,
              detector_threshold_pin_i, sda_i, scl_i}),
    .sync_o(sync_out)
  );

  assign {raw_s, rate_s, mode_s, rxs_s, thr_s, sda_s, scl_s} = sync_out;

  // ********************************************************************
  // Bus condition detection
  // ********************************************************************
  logic scl_q;
  logic sda_q;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      scl_q <= 1'b0;
      sda_q <= 1'b0;
    end
    else
    begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  assign scl_rise = scl_s && !scl_q;
  assign scl_fall = !scl_s && scl_q;
  assign start_cond = scl_s && scl_q && sda_q && !sda_s;
  assign stop_cond = scl_s && scl_q && !sda_q && sda_s;

  // ********************************************************************
  // Registers
  // ********************************************************************
  logic [7:0] pin_override_control;
  logic [7:0] reserved_a;
  logic [7:0] reserved_b;
  logic [7:0] reserved_c;
  logic [7:0] lane0_detector_force;
  logic [7:0] signal_presence_monitor;
  rosr_pkg::rosr_smb_state_t state;
  logic [7:0] sh;
  logic [3:0] cnt;
  logic [7:0] ptr;
  logic rw;
  logic nack;
  logic drive_low;
  logic wr_stb;
  logic [7:0] wr_offs;
  logic [7:0] wr_data;
  logic [7:0] rd_data;

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      pin_override_control <= rosr_pkg::RST_PIN_OVERRIDE;
    else if (wr_stb && wr_offs == rosr_pkg::OFFS_PIN_OVERRIDE)
      pin_override_control <= wr_data;
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      lane0_detector_force <= rosr_pkg::RST_LANE0_FORCE;
    else if (wr_stb && wr_offs == rosr_pkg::OFFS_LANE0_FORCE)
      lane0_detector_force <= wr_data;
  end

  // Reserved locations keep what the host writes
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      reserved_a <= rosr_pkg::RST_RESERVED_A;
      reserved_b <= rosr_pkg::RST_RESERVED_B;
      reserved_c <= rosr_pkg::RST_RESERVED_C;
    end
    else if (wr_stb)
    begin
      if (wr_offs == rosr_pkg::OFFS_RESERVED_A)
        reserved_a <= wr_data;
      if (wr_offs == rosr_pkg::OFFS_RESERVED_B)
        reserved_b <= wr_data;
      if (wr_offs == rosr_pkg::OFFS_RESERVED_C)
        reserved_c <= wr_data;
    end
  end

  always_comb
  begin
    unique case (rd_ptr_sel(ptr))
      3'd0: rd_data = pin_override_control;
      3'd1: rd_data = reserved_a;
      3'd2: rd_data = signal_presence_monitor;
      3'd3: rd_data = reserved_b;
      3'd4: rd_data = reserved_c;
      3'd5: rd_data = lane0_detector_force;
      default: rd_data = rosr_pkg::UNMAPPED_READ;
    endcase
  end

  // ********************************************************************
  // Signal detect and pin override
  // ********************************************************************
  logic force_on;
  logic force_off;
  logic [LANES-1:0] lane_present;

  assign force_on = lane0_detector_force[rosr_pkg::BIT_FORCE_ON];
  assign force_off = lane0_detector_force[rosr_pkg::BIT_FORCE_OFF];

  always_comb
  begin
    lane_present = raw_s;
    if (force_off)
      lane_present[0] = 1'b0;
    else if (force_on)
      lane_present[0] = 1'b1;
  end

  // Contents held while rate pin is driven
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      signal_presence_monitor <= rosr_pkg::RST_PRESENCE_MON;
    else if (rate_s)
      signal_presence_monitor <= ~lane_present;
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      detector_threshold_o <= 1'b0;
      receiver_sense_o <= 2'h0;
      mode_sel_o <= 1'b0;
      output_idle_o <= '0;
      lane_present_o <= '0;
    end
    else
    begin
      detector_threshold_o <= pin_override_control[rosr_pkg::BIT_THR_BLOCK] ? threshold_reg_i : thr_s;
      output_idle_o <= pin_override_control[rosr_pkg::BIT_IDLE_REGS] ? lane_idle_sel_i : ~lane_present;
      receiver_sense_o <= pin_override_control[rosr_pkg::BIT_RX_BLOCK] ? rx_mode_reg_i : rxs_s;
      mode_sel_o <= pin_override_control[rosr_pkg::BIT_MODE_BLOCK] ? mode_reg_i : mode_s;
      lane_present_o <= lane_present;
    end
  end

  // ********************************************************************
  // Serial slave engine
  // ********************************************************************
  function automatic logic [2:0] rd_ptr_sel(input logic [7:0] offs);
    logic [2:0] sel;
    sel = 3'd7;
    if (offs == rosr_pkg::OFFS_PIN_OVERRIDE) sel = 3'd0;
    if (offs == rosr_pkg::OFFS_RESERVED_A) sel = 3'd1;
    if (offs == rosr_pkg::OFFS_PRESENCE_MON) sel = 3'd2;
    if (offs == rosr_pkg::OFFS_RESERVED_B) sel = 3'd3;
    if (offs == rosr_pkg::OFFS_RESERVED_C) sel = 3'd4;
    if (offs == rosr_pkg::OFFS_LANE0_FORCE) sel = 3'd5;
    return sel;
  endfunction

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state <= rosr_pkg::SMB_IDLE;
      sh <= 8'h00;
      cnt <= 4'h0;
      ptr <= 8'h00;
      rw <= 1'b0;
      nack <= 1'b0;
      drive_low <= 1'b0;
      wr_stb <= 1'b0;
      wr_offs <= 8'h00;
      wr_data <= 8'h00;
    end
    else
    begin
      wr_stb <= 1'b0;
      if (start_cond)
      begin
        state <= rosr_pkg::SMB_ADDR;
        cnt <= 4'h0;
        drive_low <= 1'b0;
      end
      else if (stop_cond)
      begin
        state <= rosr_pkg::SMB_IDLE;
        drive_low <= 1'b0;
      end
      else if (scl_rise)
      begin
        unique case (state)
          rosr_pkg::SMB_ADDR, rosr_pkg::SMB_OFFS, rosr_pkg::SMB_WDATA:
          begin
            sh <= {sh[6:0], sda_s};
            cnt <= cnt + 4'h1;
          end
          rosr_pkg::SMB_RDATA: cnt <= cnt + 4'h1;
          rosr_pkg::SMB_RDATA_ACK: nack <= sda_s;
          default: ;
        endcase
      end
      else if (scl_fall)
      begin
        unique case (state)
          rosr_pkg::SMB_ADDR:
            if (cnt == rosr_pkg::BITS_PER_BYTE)
            begin
              if (sh[7:1] == SLAVE_ADDR)
              begin
                state <= rosr_pkg::SMB_ADDR_ACK;
                rw <= sh[0];
                drive_low <= 1'b1;
              end
              else
                state <= rosr_pkg::SMB_IDLE;
            end
          rosr_pkg::SMB_ADDR_ACK:
          begin
            cnt <= 4'h0;
            if (rw)
            begin
              state <= rosr_pkg::SMB_RDATA;
              sh <= rd_data;
              ptr <= ptr + 8'h01;
              drive_low <= !rd_data[7];
            end
            else
            begin
              state <= rosr_pkg::SMB_OFFS;
              drive_low <= 1'b0;
            end
          end
          rosr_pkg::SMB_OFFS:
            if (cnt == rosr_pkg::BITS_PER_BYTE)
            begin
              ptr <= sh;
              state <= rosr_pkg::SMB_OFFS_ACK;
              drive_low <= 1'b1;
            end
          rosr_pkg::SMB_OFFS_ACK, rosr_pkg::SMB_WDATA_ACK:
          begin
            cnt <= 4'h0;
            state <= rosr_pkg::SMB_WDATA;
            drive_low <= 1'b0;
          end
          rosr_pkg::SMB_WDATA:
            if (cnt == rosr_pkg::BITS_PER_BYTE)
            begin
              wr_stb <= 1'b1;
              wr_offs <= ptr;
              wr_data <= sh;
              ptr <= ptr + 8'h01;
              state <= rosr_pkg::SMB_WDATA_ACK;
              drive_low <= 1'b1;
            end
          rosr_pkg::SMB_RDATA:
            if (cnt == rosr_pkg::BITS_PER_BYTE)
            begin
              state <= rosr_pkg::SMB_RDATA_ACK;
              drive_low <= 1'b0;
            end
            else
            begin
              sh <= {sh[6:0], 1'b0};
              drive_low <= !sh[6];
            end
          rosr_pkg::SMB_RDATA_ACK:
          begin
            cnt <= 4'h0;
            if (nack)
              state <= rosr_pkg::SMB_IDLE;
            else
            begin
              state <= rosr_pkg::SMB_RDATA;
              sh <= rd_data;
              ptr <= ptr + 8'h01;
              drive_low <= !rd_data[7];
            end
          end
          default: ;
        endcase
      end
    end
  end

  // Open drain: only ever pulls low
  assign sda_o = 1'b0;
  assign sda_oe_n_o = !drive_low;

  // ********************************************************************
  // Checks
  // ********************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  chk_thr_blocked:
    assert property (pin_override_control[6] |=> detector_threshold_o == $past(threshold_reg_i))
    else $error("threshold not taken from register");
  chk_thr_pin:
    assert property (!pin_override_control[6] |=> detector_threshold_o == $past(thr_s))
    else $error("threshold not taken from pin");
  chk_idle_regs:
    assert property (pin_override_control[4] |=> output_idle_o == $past(lane_idle_sel_i))
    else $error("idle not taken from register fields");
  chk_rx_blocked:
    assert property (pin_override_control[3] |=> receiver_sense_o == $past(rx_mode_reg_i))
    else $error("receiver sense not taken from register");
  chk_mode_pin:
    assert property (!pin_override_control[2] |=> mode_sel_o == $past(mode_s))
    else $error("mode not taken from pin");
  chk_monitor_inverts:
    assert property (rate_s && !force_on && !force_off |=> signal_presence_monitor == ~$past(raw_s))
    else $error("presence vector not inverted detector");
  chk_monitor_hold:
    assert property (!rate_s |=> $stable(signal_presence_monitor))
    else $error("presence vector changed with rate pin driven");
  chk_force_on:
    assert property (force_on && !force_off |=> lane_present_o[0])
    else $error("force on ignored");
  chk_force_off_wins:
    assert property (force_off ##1 force_off |=> !lane_present_o[0] && output_idle_o[0] == !pin_override_control[4]
                     || pin_override_control[4])
    else $error("force off did not win");
  chk_read_start:
    assert property (state == rosr_pkg::SMB_ADDR_ACK && rw && scl_fall
                     |=> state == rosr_pkg::SMB_RDATA && drive_low == !sh[7])
    else $error("read byte not launched after address ack");

  cov_read_done: cover property (state == rosr_pkg::SMB_RDATA_ACK && scl_fall && nack);
  cov_override_write: cover property (wr_stb && wr_offs == rosr_pkg::OFFS_PIN_OVERRIDE);
  cov_both_force: cover property (force_on && force_off);

endmodule

// >>> bench/rosr_host_model.sv
`timescale 1ns/100ps

// ********************************************************************
// SMBus host on the register side
// ********************************************************************
module rosr_host_model
#(
  parameter logic [6:0] DEV_ADDR = 7'h18
)
(
  input wire logic clk_i,
  input wire logic sda_bus_i,
  output logic scl_o,
  output logic sda_o
);
  initial
  begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  // Half period of SCL, above what the slave needs to sample
  task automatic hp();
    repeat (10) @(posedge clk_i);
  endtask

  task automatic start_cond();
    @(posedge clk_i);
    sda_o <= 1'b1;
    hp();
    scl_o <= 1'b1;
    hp();
    sda_o <= 1'b0;
    hp();
    scl_o <= 1'b0;
    hp();
  endtask

  task automatic stop_cond();
    sda_o <= 1'b0;
    hp();
    scl_o <= 1'b1;
    hp();
    sda_o <= 1'b1;
    hp();
  endtask

  // Drives one bit (1 releases the line) and samples the line mid-high
  task automatic clock_bit(input logic b, output logic seen);
    sda_o <= b;
    hp();
    scl_o <= 1'b1;
    repeat (5) @(posedge clk_i);
    seen = sda_bus_i;
    repeat (5) @(posedge clk_i);
    scl_o <= 1'b0;
    hp();
  endtask

  task automatic put_byte(input logic [7:0] b, output logic ack_n);
    logic s;
    for (int i = 7; i >= 0; i--)
      clock_bit(b[i], s);
    clock_bit(1'b1, ack_n);
  endtask

  task automatic get_byte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
      clock_bit(1'b1, b[i]);
    clock_bit(last, s);
  endtask

  task automatic probe(input logic [6:0] addr, output logic ack_n);
    start_cond();
    put_byte({addr, 1'b0}, ack_n);
    stop_cond();
  endtask

  task automatic write_reg(input logic [7:0] offs, input logic [7:0] data, output logic ok);
    logic a0, a1, a2;
    start_cond();
    put_byte({DEV_ADDR, 1'b0}, a0);
    put_byte(offs, a1);
    put_byte(data, a2);
    stop_cond();
    ok = !(a0 | a1 | a2);
  endtask

  // Pointer write, repeated start, one byte back closed by a not-acknowledge
  task automatic read_reg(input logic [7:0] offs, output logic [7:0] data, output logic ok);
    logic a0, a1, a2;
    start_cond();
    put_byte({DEV_ADDR, 1'b0}, a0);
    put_byte(offs, a1);
    start_cond();
    put_byte({DEV_ADDR, 1'b1}, a2);
    get_byte(1'b1, data);
    stop_cond();
    ok = !(a0 | a1 | a2);
  endtask
endmodule

// >>> bench/tb.sv
`timescale 1ns/100ps

module tb;
  logic clk, arst_n, scl, host_sda, sda_bus, sda_o, sda_oe_n, ok, nak;
  logic thr_pin, thr_reg, mode_pin, mode_reg, rate_float, thr_o, mode_o;
  logic [1:0] rx_pin, rx_reg, rx_o;
  logic [7:0] raw, idle_sel, idle_o, present_o, rd;
  logic [7:0] rst_tab [6] = '{8'h00, 8'h00, 8'h00, 8'h70, 8'h00, 8'h00};
  int failures, n_checks;

  // Open-drain data line with a pull-up
  assign sda_bus = host_sda & (sda_oe_n ? 1'b1 : sda_o);

  rosr_regs DUT (.clk_i(clk), .arst_n_i(arst_n), .scl_i(scl), .sda_i(sda_bus), .sda_o(sda_o),
    .sda_oe_n_o(sda_oe_n), .detector_threshold_pin_i(thr_pin), .threshold_reg_i(thr_reg),
    .receiver_sense_i(rx_pin), .rx_mode_reg_i(rx_reg), .mode_pin_i(mode_pin), .mode_reg_i(mode_reg),
    .rate_float_i(rate_float), .lane_signal_raw_i(raw), .lane_idle_sel_i(idle_sel),
    .detector_threshold_o(thr_o), .receiver_sense_o(rx_o), .mode_sel_o(mode_o),
    .output_idle_o(idle_o), .lane_present_o(present_o));

  rosr_host_model #(.DEV_ADDR(rosr_pkg::DEFAULT_SLAVE_ADDR)) host (.clk_i(clk), .sda_bus_i(sda_bus),
    .scl_o(scl), .sda_o(host_sda));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ********************************************************************
  // Helpers
  // ********************************************************************
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic settle();
    repeat (6) @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.write_reg(a, d, ok);
    chk("write ack", {7'h00, ok}, 8'h01);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
    host.read_reg(a, rd, ok);
    chk("read ack", {7'h00, ok}, 8'h01);
    chk(what, rd, exp);
  endtask

  task automatic ovr(input logic [7:0] v, input logic e_thr, input logic [1:0] e_rx, input logic e_mode,
    input logic [7:0] e_idle);
    wr(8'h08, v);
    settle();
    chk("threshold", {7'h00, thr_o}, {7'h00, e_thr});
    chk("receiver sense", {6'h00, rx_o}, {6'h00, e_rx});
    chk("mode", {7'h00, mode_o}, {7'h00, e_mode});
    chk("output idle", idle_o, e_idle);
  endtask

  task automatic wrap_up();
    if (failures == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    repeat (90000) @(posedge clk);
    failures++;
    wrap_up();
  end

  // ********************************************************************
  // Tests
  // ********************************************************************
  initial
  begin
    failures = 0;
    n_checks = 0;
    arst_n = 1'b0;
    thr_pin = 1'b1;
    thr_reg = 1'b0;
    rx_pin = 2'b10;
    rx_reg = 2'b01;
    mode_pin = 1'b1;
    mode_reg = 1'b0;
    rate_float = 1'b0;
    raw = 8'h3c;
    idle_sel = 8'ha5;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    repeat (8) @(posedge clk);
    for (int i = 0; i < 6; i++)
      rd_chk(8'h08 + 8'(i), rst_tab[i], "reset value");
    chk("present", present_o, 8'h3c);
    ovr(8'h00, 1'b1, 2'b10, 1'b1, 8'hc3);
    ovr(8'h5c, 1'b0, 2'b01, 1'b0, 8'ha5);
    thr_pin <= 1'b0;
    rx_pin <= 2'b11;
    mode_pin <= 1'b0;
    thr_reg <= 1'b1;
    rx_reg <= 2'b00;
    mode_reg <= 1'b1;
    ovr(8'h5c, 1'b1, 2'b00, 1'b1, 8'ha5);
    ovr(8'h40, 1'b1, 2'b11, 1'b0, 8'hc3);
    ovr(8'h10, 1'b0, 2'b11, 1'b0, 8'ha5);
    ovr(8'h08, 1'b0, 2'b00, 1'b0, 8'hc3);
    ovr(8'h04, 1'b0, 2'b11, 1'b1, 8'hc3);
    ovr(8'h00, 1'b0, 2'b11, 1'b0, 8'hc3);
    rate_float <= 1'b1;
    settle();
    rd_chk(8'h0a, 8'hc3, "monitor");
    wr(8'h0a, 8'h55);
    rd_chk(8'h0a, 8'hc3, "monitor read only");
    rate_float <= 1'b0;
    raw <= 8'h0f;
    settle();
    chk("present", present_o, 8'h0f);
    rd_chk(8'h0a, 8'hc3, "monitor held");
    rate_float <= 1'b1;
    for (int n = 0; n < 8; n++)
    begin
      raw <= 8'h01 << n;
      settle();
      rd_chk(8'h0a, ~(8'h01 << n), "monitor lane");
    end
    raw <= 8'hfe;
    wr(8'h0d, 8'h02);
    settle();
    chk("present", present_o, 8'hff);
    chk("output idle", idle_o, 8'h00);
    rd_chk(8'h0a, 8'h00, "monitor forced on");
    wr(8'h0d, 8'h06);
    settle();
    chk("present", present_o, 8'hfe);
    rd_chk(8'h0a, 8'h01, "monitor both forces");
    raw <= 8'hff;
    wr(8'h0d, 8'h04);
    settle();
    chk("present", present_o, 8'hfe);
    wr(8'h0d, 8'h00);
    settle();
    chk("present", present_o, 8'hff);
    wr(8'h0b, 8'h70);
    rd_chk(8'h0b, 8'h70, "reserved b");
    host.write_reg(8'h20, 8'h5a, ok);
    host.read_reg(8'h20, rd, ok);
    chk("unmapped", rd, 8'h00);
    host.probe(rosr_pkg::DEFAULT_SLAVE_ADDR ^ 7'h01, nak);
    chk("foreign address nack", {7'h00, nak}, 8'h01);
    wr(8'h0d, 8'h02);
    arst_n <= 1'b0;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    repeat (8) @(posedge clk);
    rd_chk(8'h0d, 8'h00, "force after reset");
    chk("present", present_o, 8'hff);
    wrap_up();
  end
endmodule
